// *** wrap_zone_ctrl.sv ***
/*
  Wrap-around position, turn counter and blocking zone of a motion
  controller, with its register port.
  Assumes the ramp generator issues one-cycle step pulses and acts on
  routeUp and stopRampStart; target, ramp kind, half range and latched
  position come from registers kept elsewhere in the device.
*/
// Overview of operation
// (R1) Count turn up on forward wrap.
// (R2) Count turn down on reverse wrap.
// (R3) Index 0x36 reads latched position normally.
// (R4) Readout select bit swaps in turn count.
// (R5) Turn count zero while circular mode off.
// (R6) Zone only with wrap on, range nonzero.
// (R7) Zone limits from indices 0x33, 0x34.
// (R8) Positioning routes around the zone.
// (R9) Limit reached starts soft-limit stop ramp.
// (R10) Low below high: either side inside.
// (R11) Low above high: both sides inside.
// (R12) Host writes limits before enabling them.
// (R13) No zone: take shortest direction.
// (R14) Host exit: positioning, clear events, outside target.
// (R15) After exit, shortest route to target.
// (R16) Reading events clears soft-limit stop flags.
// (R17) Encoder wraps when its enable set.
// (R18) Turn completes at the wrap point.
// (R19) Fraction accumulates; carry holds one step.
// (R20) Turn count signed, wraps silently.
`timescale 1ns/1ps
module wrap_zone_ctrl
  import wrap_zone_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [6:0] regAddr,
  input wire logic regWrEn,
  input wire logic [31:0] regWrData,
  input wire logic regRdEn,
  output logic [31:0] regRdData,
  output logic regRdValid,
  input wire logic stepReq,
  input wire logic stepUp,
  input wire logic encStepReq,
  input wire logic encStepUp,
  input wire logic signed [POS_W-1:0] halfRange,
  input wire logic signed [POS_W-1:0] targetPosition,
  input wire logic [2:0] rampKind,
  input wire logic signed [POS_W-1:0] latchedPosition,
  output logic signed [POS_W-1:0] actualPosition,
  output logic signed [POS_W-1:0] encoderPosition,
  output logic routeUp,
  output logic stopRampStart,
  output logic zoneBlocked
);
  logic [31:0] generalConfig_r;
  logic [31:0] referenceConfig_r;
  logic signed [POS_W-1:0] lowLimit_r;
  logic signed [POS_W-1:0] highLimit_r;
  logic [31:0] fraction_r;
  logic [1:0] events_r;
  logic [1:0] events_nxt;
  logic signed [31:0] turnCount_r;
  logic [31:0] rdData_r;
  logic rdValid_r;
  logic routeUp_r;
  logic stop_r;
  zone_state_t zone_r;
  zone_state_t zone_nxt;
  logic circularOn;
  logic wrapOn;
  logic limitsOn;
  logic targetInZone;
  logic leaveOk;
  logic zoneActive;
  logic positioning;
  logic lowHit;
  logic highHit;
  logic inZone;
  logic routeUpComb;
  logic avoidZone;
  logic enterZone;
  logic readEvents;
  logic [1:0] setEvents;
  logic [31:0] rdMux;

  pos_if #(.W(POS_W)) actIf ();
  pos_if #(.W(POS_W)) encIf ();

  assign circularOn = referenceConfig_r[RC_CIRCULAR_BIT];
  // Wrap needs a nonzero range; a zero range leaves plain counters
  assign wrapOn = circularOn && (halfRange != '0);
  assign limitsOn = referenceConfig_r[RC_LOW_LIMIT_EN_BIT]
    && referenceConfig_r[RC_HIGH_LIMIT_EN_BIT];
  assign zoneActive = wrapOn && limitsOn; // R6
  assign positioning = rampKind[RAMP_KIND_POS_BIT];

  assign actIf.stepReq = stepReq;
  assign actIf.stepUp = stepUp;
  assign actIf.wrapEn = wrapOn;
  assign actIf.halfRange = halfRange;
  assign actIf.fraction = fraction_r;

  // Encoder follows the same wrap, without the fractional hold
  assign encIf.stepReq = encStepReq;
  assign encIf.stepUp = encStepUp;
  assign encIf.wrapEn = wrapOn && referenceConfig_r[RC_ENC_WRAP_BIT]; // R17
  assign encIf.halfRange = halfRange;
  assign encIf.fraction = 32'h0000_0000;

  wrap_position actPos (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .p(actIf.owner)
  );

  wrap_position encPos (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .p(encIf.owner)
  );

  // The zone is avoided only while not escaping it; escaping takes
  // the shortest route even though it starts inside the zone
  assign avoidZone = zoneActive && (zone_r != ZS_LEAVING); // R15

  zone_route route (
    .actual(actIf.position),
    .target(targetPosition),
    .lowLimit(lowLimit_r), // R7
    .highLimit(highLimit_r), // R7
    .halfRange(halfRange),
    .wrapOn(actIf.wrapEn),
    .avoidZone(avoidZone),
    .lowHit(lowHit),
    .highHit(highHit),
    .inZone(inZone),
    .routeUp(routeUpComb)
  );

  // Same membership test on the target: the escape route is granted only
  // toward a target outside the zone, otherwise the ramp would stop again
  zone_route targetZone (
    .actual(targetPosition),
    .target(targetPosition),
    .lowLimit(lowLimit_r),
    .highLimit(highLimit_r),
    .halfRange(halfRange),
    .wrapOn(wrapOn),
    .avoidZone(1'b0),
    .lowHit(),
    .highHit(),
    .inZone(targetInZone),
    .routeUp()
  );

  assign enterZone = (zone_r == ZS_FREE) && zoneActive && inZone;
  assign readEvents = regRdEn && (regAddr == ADDR_EVENT_FLAGS);
  // Leaving needs positioning mode, cleared events and a target outside
  assign leaveOk = positioning && (events_r == 2'h0) && !targetInZone; // R14

  // Register writes
  // Read-only and unmapped indices fall through and are ignored
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      generalConfig_r <= GENERAL_CONFIG_RST;
      referenceConfig_r <= REFERENCE_CONFIG_RST;
      lowLimit_r <= LIMIT_RST;
      highLimit_r <= LIMIT_RST;
      fraction_r <= FRACTION_RST;
    end else if (regWrEn) begin
      case (regAddr)
        ADDR_GENERAL_CONFIG: generalConfig_r <= regWrData;
        ADDR_REFERENCE_CONFIG: referenceConfig_r <= regWrData;
        ADDR_LOW_SOFT_LIMIT: lowLimit_r <= regWrData; // R7
        ADDR_HIGH_SOFT_LIMIT: highLimit_r <= regWrData; // R7
        ADDR_FRACTION_PER_TURN: fraction_r <= regWrData; // R19
        default: ;
      endcase
    end
  end

  // Turn counter
  // It follows the wrap pulse, so it lags the position by one cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      turnCount_r <= '0;
    end else if (!circularOn) begin
      turnCount_r <= '0; // R5
    end else if (actIf.wrapUp) begin
      turnCount_r <= turnCount_r + 32'sh0000_0001; // R1 R20
    end else if (actIf.wrapDown) begin
      turnCount_r <= turnCount_r - 32'sh0000_0001; // R2 R20
    end
  end

  // Zone state: blocked after a limit hit until the escape conditions hold
  always_comb begin
    zone_nxt = zone_r;
    case (zone_r)
      ZS_FREE: begin
        if (enterZone) begin
          zone_nxt = ZS_BLOCKED;
        end
      end
      ZS_BLOCKED: begin
        if (!zoneActive) begin
          zone_nxt = ZS_FREE;
        end else if (leaveOk) begin
          zone_nxt = ZS_LEAVING; // R14
        end
      end
      ZS_LEAVING: begin
        // Escape ends once the position is clear of the zone
        if (!zoneActive || !inZone) begin
          zone_nxt = ZS_FREE;
        end
      end
      default: zone_nxt = ZS_FREE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      zone_r <= ZS_FREE;
    end else begin
      zone_r <= zone_nxt;
    end
  end

  // Flag for the limit that was met: the travel direction tells which
  always_comb begin
    setEvents = 2'h0;
    if (enterZone) begin
      setEvents[EV_HIGH_STOP_BIT] = actIf.lastUp && highHit;
      setEvents[EV_LOW_STOP_BIT] = !(actIf.lastUp && highHit) && (lowHit || !highHit);
    end
    // Set wins over the read that clears
    events_nxt = (readEvents ? 2'h0 : events_r) | setEvents; // R16
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      events_r <= EVENT_RST;
    end else begin
      events_r <= events_nxt;
    end
  end

  // Stop ramp request and route
  // One-cycle request; the ramp generator keeps its own stop state
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stop_r <= 1'b0;
      routeUp_r <= 1'b1;
    end else begin
      stop_r <= enterZone; // R9
      routeUp_r <= routeUpComb; // R8 R13
    end
  end

  // Register reads
  // Data is registered so an events read and its clear share one edge
  always_comb begin
    case (regAddr)
      ADDR_GENERAL_CONFIG: rdMux = generalConfig_r;
      ADDR_REFERENCE_CONFIG: rdMux = referenceConfig_r;
      ADDR_EVENT_FLAGS: rdMux = {30'h0, events_r};
      ADDR_LOW_SOFT_LIMIT: rdMux = lowLimit_r;
      ADDR_HIGH_SOFT_LIMIT: rdMux = highLimit_r;
      ADDR_LATCH_OR_TURN: begin
        if (generalConfig_r[GC_TURN_READOUT_BIT]) begin
          rdMux = turnCount_r; // R4
        end else begin
          rdMux = latchedPosition; // R3
        end
      end
      ADDR_FRACTION_PER_TURN: rdMux = fraction_r;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdData_r <= 32'h0000_0000;
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= regRdEn;
      if (regRdEn) begin
        rdData_r <= rdMux;
      end
    end
  end

  assign regRdData = rdData_r;
  assign regRdValid = rdValid_r;
  assign actualPosition = actIf.position;
  assign encoderPosition = encIf.position;
  assign routeUp = routeUp_r;
  assign stopRampStart = stop_r;
  assign zoneBlocked = (zone_r == ZS_BLOCKED);
endmodule : wrap_zone_ctrl

// *** wrap_zone_pkg.sv ***
/*
  Constants shared by the wrap-around position and blocking-zone logic:
  register indices, field positions, reset values and zone states.
  Assumes word-wide registers reached by index on the register port.
*/
package wrap_zone_pkg;

  localparam int POS_W = 32;

  localparam logic [6:0] ADDR_GENERAL_CONFIG = 7'h00;
  localparam logic [6:0] ADDR_REFERENCE_CONFIG = 7'h01;
  localparam logic [6:0] ADDR_EVENT_FLAGS = 7'h0E;
  localparam logic [6:0] ADDR_LOW_SOFT_LIMIT = 7'h33;
  localparam logic [6:0] ADDR_HIGH_SOFT_LIMIT = 7'h34;
  localparam logic [6:0] ADDR_LATCH_OR_TURN = 7'h36;
  localparam logic [6:0] ADDR_FRACTION_PER_TURN = 7'h7C;

  localparam int GC_TURN_READOUT_BIT = 0;
  localparam int RC_CIRCULAR_BIT = 0;
  localparam int RC_LOW_LIMIT_EN_BIT = 1;
  localparam int RC_HIGH_LIMIT_EN_BIT = 2;
  localparam int RC_ENC_WRAP_BIT = 3;
  localparam int EV_LOW_STOP_BIT = 0;
  localparam int EV_HIGH_STOP_BIT = 1;
  localparam int RAMP_KIND_POS_BIT = 2;

  localparam logic [31:0] GENERAL_CONFIG_RST = 32'h0000_0000;
  localparam logic [31:0] REFERENCE_CONFIG_RST = 32'h0000_0000;
  localparam logic [31:0] LIMIT_RST = 32'h0000_0000;
  localparam logic [31:0] FRACTION_RST = 32'h0000_0000;
  localparam logic [1:0] EVENT_RST = 2'h0;

  typedef enum logic [2:0] {
    ZS_FREE = 3'b001,
    ZS_BLOCKED = 3'b010,
    ZS_LEAVING = 3'b100
  } zone_state_t;

endpackage : wrap_zone_pkg

// *** pos_if.sv ***
/*
  Carrier between a position owner and its user: step requests in,
  position and wrap pulses out.
  Assumes one clock domain shared by both ends.
*/
`timescale 1ns/1ps
interface pos_if #(parameter int W = 32);
  logic stepReq;
  logic stepUp;
  logic wrapEn;
  logic signed [W-1:0] halfRange;
  logic [31:0] fraction;
  logic signed [W-1:0] position;
  logic wrapUp;
  logic wrapDown;
  logic lastUp;

  modport owner (
    input stepReq, stepUp, wrapEn, halfRange, fraction,
    output position, wrapUp, wrapDown, lastUp
  );
  modport user (
    output stepReq, stepUp, wrapEn, halfRange, fraction,
    input position, wrapUp, wrapDown, lastUp
  );
endinterface : pos_if

// *** wrap_position.sv ***
/*
  One wrapping position counter with a fractional-turn accumulator.
  Assumes step requests are one-cycle pulses synchronous to sys_clk.
*/
`timescale 1ns/1ps
module wrap_position
  import wrap_zone_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  pos_if.owner p
);
  logic signed [POS_W-1:0] pos_r;
  logic [30:0] acc_r;
  logic [1:0] hold_r;
  logic wrapUp_r;
  logic wrapDown_r;
  logic lastUp_r;
  logic [31:0] accSum;
  logic [1:0] extraSteps;
  logic atTop;
  logic atBottom;

  // Bit 31 of the fraction is a whole step; bits 30:0 carry into one more
  assign accSum = {1'b0, acc_r} + {1'b0, p.fraction[30:0]};
  assign extraSteps = {1'b0, p.fraction[31]} + {1'b0, accSum[31]};
  assign atTop = (pos_r == p.halfRange - 1);
  assign atBottom = (pos_r == -p.halfRange);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pos_r <= '0;
      acc_r <= '0;
      hold_r <= 2'h0;
      wrapUp_r <= 1'b0;
      wrapDown_r <= 1'b0;
      lastUp_r <= 1'b1;
    end else begin
      wrapUp_r <= 1'b0;
      wrapDown_r <= 1'b0;
      if (!p.wrapEn) begin
        hold_r <= 2'h0;
        acc_r <= '0;
      end
      if (p.stepReq) begin
        lastUp_r <= p.stepUp;
        if (p.wrapEn && (hold_r != 2'h0)) begin
          // Extra step spent at the wrap point
          hold_r <= hold_r - 2'h1; // R19
        end else if (p.wrapEn && p.stepUp && atTop) begin
          pos_r <= -p.halfRange; // R18
          wrapUp_r <= 1'b1;
          acc_r <= accSum[30:0]; // R19
          hold_r <= extraSteps; // R19
        end else if (p.wrapEn && !p.stepUp && atBottom) begin
          pos_r <= p.halfRange - 1; // R18
          wrapDown_r <= 1'b1;
          acc_r <= accSum[30:0]; // R19
          hold_r <= extraSteps; // R19
        end else if (p.stepUp) begin
          pos_r <= pos_r + 1;
        end else begin
          pos_r <= pos_r - 1;
        end
      end
    end
  end

  assign p.position = pos_r;
  assign p.wrapUp = wrapUp_r;
  assign p.wrapDown = wrapDown_r;
  assign p.lastUp = lastUp_r;
endmodule : wrap_position

// *** zone_route.sv ***
/*
  Combinational zone membership and route choice.
  Assumes positions lie inside the wrap range when wrap is on.
*/
`timescale 1ns/1ps
module zone_route
  import wrap_zone_pkg::*;
(
  input wire logic signed [POS_W-1:0] actual,
  input wire logic signed [POS_W-1:0] target,
  input wire logic signed [POS_W-1:0] lowLimit,
  input wire logic signed [POS_W-1:0] highLimit,
  input wire logic signed [POS_W-1:0] halfRange,
  input wire logic wrapOn,
  input wire logic avoidZone,
  output logic lowHit,
  output logic highHit,
  output logic inZone,
  output logic routeUp
);
  logic signed [POS_W:0] diff;
  logic signed [POS_W:0] fwd;
  logic shortUp;
  logic avoidUp;

  always_comb begin
    lowHit = (actual <= lowLimit);
    highHit = (actual >= highLimit);
    if (lowLimit < highLimit) begin
      inZone = lowHit | highHit; // R10
    end else begin
      inZone = lowHit & highHit; // R11
    end
    diff = {target[POS_W-1], target} - {actual[POS_W-1], actual};
    fwd = diff[POS_W] ? diff + {halfRange, 1'b0} : diff;
    shortUp = wrapOn ? (fwd <= {halfRange[POS_W-1], halfRange}) : (diff > 0); // R13
    if (lowLimit < highLimit) begin
      // Free span does not cross the wrap point, so go straight
      avoidUp = (target > actual); // R8
    end else if (target > actual) begin
      avoidUp = !((actual < highLimit) && (target >= highLimit)); // R8
    end else begin
      avoidUp = (actual > lowLimit) && (target <= lowLimit); // R8
    end
    routeUp = avoidZone ? avoidUp : shortUp;
  end
endmodule : zone_route

// *** wrap_zone_ctrl_asserts.sv ***
/*
  Concurrent checks on the top ports of the wrap-around position block.
  Assumes registers change only through the word-wide register port.
*/
`timescale 1ns/1ps
module wrap_zone_ctrl_asserts
  import wrap_zone_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [6:0] regAddr,
  input wire logic regWrEn,
  input wire logic [31:0] regWrData,
  input wire logic regRdEn,
  input wire logic [31:0] regRdData,
  input wire logic regRdValid,
  input wire logic stepReq,
  input wire logic stepUp,
  input wire logic signed [POS_W-1:0] halfRange,
  input wire logic [2:0] rampKind,
  input wire logic signed [POS_W-1:0] latchedPosition,
  input wire logic signed [POS_W-1:0] actualPosition,
  input wire logic stopRampStart,
  input wire logic zoneBlocked
);
  logic circ_r, sel_r, zoneEn_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Mirror of the config bits, updated on the same edge as the block's own copy
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      circ_r <= 1'b0;
      sel_r <= 1'b0;
      zoneEn_r <= 1'b0;
    end else if (regWrEn) begin
      if (regAddr == ADDR_REFERENCE_CONFIG) begin
        circ_r <= regWrData[RC_CIRCULAR_BIT];
        zoneEn_r <= regWrData[RC_LOW_LIMIT_EN_BIT] && regWrData[RC_HIGH_LIMIT_EN_BIT];
      end
      if (regAddr == ADDR_GENERAL_CONFIG) sel_r <= regWrData[GC_TURN_READOUT_BIT];
    end
  end
  AST_RD_ONE: assert property (regRdEn |=> regRdValid)
    else $error("read answer missing");
  AST_LATCH_RD: assert property (regRdEn && regAddr == ADDR_LATCH_OR_TURN && !sel_r
    |=> regRdData == $past(latchedPosition)) else $error("latched readout wrong");
  AST_TURN_OFF: assert property (regRdEn && regAddr == ADDR_LATCH_OR_TURN && sel_r
    && !circ_r && !$past(circ_r) |=> regRdData == 32'h0) else $error("turn count not zero");
  AST_STEP_UP: assert property (stepReq && stepUp && actualPosition != -halfRange
    && actualPosition != halfRange - 1 |=> actualPosition == $past(actualPosition) + 1)
    else $error("step up miscounted");
  AST_WRAP_UP: assert property (circ_r && halfRange != 0 && stepReq && stepUp
    && actualPosition == halfRange - 1 |=> actualPosition == -halfRange || $stable(actualPosition))
    else $error("forward wrap wrong");
  AST_WRAP_DN: assert property (circ_r && halfRange != 0 && stepReq && !stepUp
    && actualPosition == -halfRange |=> actualPosition == halfRange - 1 || $stable(actualPosition))
    else $error("reverse wrap wrong");
  AST_STOP_ONE: assert property (stopRampStart |=> !stopRampStart && zoneBlocked)
    else $error("stop pulse wrong");
  AST_ZONE_GATE: assert property (stopRampStart |-> $past(circ_r) && $past(halfRange) != 0)
    else $error("zone active without wrap");
  AST_EV_CLR: assert property ((regRdEn && regAddr == ADDR_EVENT_FLAGS) ##1 !stopRampStart
    ##1 (regRdEn && regAddr == ADDR_EVENT_FLAGS && !stopRampStart) |=> regRdData == 32'h0)
    else $error("events not cleared");
  AST_BLOCK_HOLD: assert property (zoneBlocked && !rampKind[RAMP_KIND_POS_BIT] && circ_r
    && zoneEn_r && halfRange != 0 |=> zoneBlocked) else $error("zone left without positioning");
endmodule : wrap_zone_ctrl_asserts

bind wrap_zone_ctrl wrap_zone_ctrl_asserts u_wrap_zone_ctrl_asserts (
  .sys_clk, .rst_n, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData, .regRdValid,
  .stepReq, .stepUp, .halfRange, .rampKind, .latchedPosition, .actualPosition,
  .stopRampStart, .zoneBlocked
);

// *** host_bus_model.sv ***
/*
  Host model: word writes and reads on the register port.
  Assumes read data arrives exactly one cycle after the read strobe.
*/
`timescale 1ns/1ps
module host_bus_model (
  input wire logic sys_clk,
  output logic [6:0] regAddr,
  output logic regWrEn,
  output logic [31:0] regWrData,
  output logic regRdEn,
  input wire logic [31:0] regRdData,
  input wire logic regRdValid
);
  initial begin
    regAddr = 7'h7F;
    regWrEn = 1'b0;
    regWrData = 32'h0;
    regRdEn = 1'b0;
  end
  // Idle address and data are inverted so the block cannot lean on stale values
  task wr(input logic [6:0] a, input logic [31:0] d);
    @(negedge sys_clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge sys_clk);
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask : wr
  task rd(input logic [6:0] a, output logic [31:0] d);
    @(negedge sys_clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge sys_clk);
    regRdEn = 1'b0;
    regAddr = ~a;
    d = regRdValid ? regRdData : 32'hXXXX_XXXX;
  endtask : rd
endmodule : host_bus_model

// *** wrap_turn_counter_blocking_zone_test.sv ***
/*
  Self-checking bench for the wrap-around position and blocking zone.
  Assumes the host model owns the register port; steps come from here.
*/
`timescale 1ns/1ps
module wrap_turn_counter_blocking_zone_test;
  import wrap_zone_pkg::*;
  logic sys_clk, rst_n, regWrEn, regRdEn, regRdValid, stepReq, stepUp, encStepReq, encStepUp;
  logic routeUp, stopRampStart, zoneBlocked;
  logic [6:0] regAddr;
  logic [31:0] regWrData, regRdData, rdv;
  logic signed [POS_W-1:0] halfRange, targetPosition, latchedPosition;
  logic signed [POS_W-1:0] actualPosition, encoderPosition;
  logic [2:0] rampKind;
  int errorCnt, checkCount;

  wrap_zone_ctrl u_wrap_zone_ctrl (.sys_clk, .rst_n, .regAddr, .regWrEn, .regWrData,
    .regRdEn, .regRdData, .regRdValid, .stepReq, .stepUp, .encStepReq, .encStepUp,
    .halfRange, .targetPosition, .rampKind, .latchedPosition, .actualPosition,
    .encoderPosition, .routeUp, .stopRampStart, .zoneBlocked);
  host_bus_model u_host_bus_model (.sys_clk, .regAddr, .regWrEn, .regWrData, .regRdEn,
    .regRdData, .regRdValid);

  task give_verdict;
    if (errorCnt == 0 && checkCount > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [6:0] a, input logic [31:0] d);
    u_host_bus_model.wr(a, d);
  endtask : wr
  task rchk(input logic [6:0] a, input logic [31:0] exp);
    u_host_bus_model.rd(a, rdv);
    chk(rdv, exp);
  endtask : rchk
  task rte(input logic [31:0] t, input logic [31:0] exp);
    targetPosition = t;
    repeat (2) @(negedge sys_clk);
    chk(routeUp, exp);
  endtask : rte
  task stp(input int n, input logic up, input logic enc);
    @(negedge sys_clk);
    stepUp = up;
    encStepUp = up;
    stepReq = !enc;
    encStepReq = enc;
    repeat (n) @(negedge sys_clk);
    stepReq = 1'b0;
    encStepReq = 1'b0;
  endtask : stp
  task t_regs;
    rchk(7'h00, 32'h0);
    rchk(7'h01, 32'h0);
    rchk(7'h0E, 32'h0);
    rchk(7'h33, 32'h0);
    rchk(7'h34, 32'h0);
    rchk(7'h7C, 32'h0);
    rchk(7'h05, 32'h0);
    rchk(7'h36, 32'h1234_5678);
    wr(7'h36, 32'h0);
    rchk(7'h36, 32'h1234_5678);
  endtask : t_regs
  task t_turn;
    halfRange = 32'h4;
    wr(7'h01, 32'h1);
    stp(3, 1'b1, 1'b0);
    chk(actualPosition, 32'h3);
    stp(1, 1'b1, 1'b0);
    chk(actualPosition, 32'hFFFF_FFFC);
    wr(7'h00, 32'h1);
    rchk(7'h36, 32'h1);
    stp(1, 1'b0, 1'b0);
    rchk(7'h36, 32'h0);
    stp(8, 1'b0, 1'b0);
    rchk(7'h36, 32'hFFFF_FFFF);
    wr(7'h01, 32'h0);
    rchk(7'h36, 32'h0);
    wr(7'h01, 32'h9);
    stp(4, 1'b1, 1'b1);
    chk(encoderPosition, 32'hFFFF_FFFC);
    // One whole step per revolution, so every wrap must stretch by one step
    wr(7'h7C, 32'h8000_0000);
    stp(1, 1'b1, 1'b0);
    chk(actualPosition, 32'hFFFF_FFFC);
    stp(1, 1'b1, 1'b0);
    chk(actualPosition, 32'hFFFF_FFFC);
    stp(1, 1'b1, 1'b0);
    chk(actualPosition, 32'hFFFF_FFFD);
    wr(7'h7C, 32'h0);
  endtask : t_turn
  task t_route;
    halfRange = 32'h12C;
    rampKind = 3'h4;
    rte(32'h64, 32'h1);
    rte(32'hFFFF_FF9C, 32'h0);
    rte(32'h129, 32'h1);
    rte(32'h12A, 32'h0);
  endtask : t_route
  task t_zone;
    wr(7'h33, 32'hC8);
    wr(7'h34, 32'h64);
    wr(7'h01, 32'h7);
    targetPosition = 32'hFA;
    repeat (2) @(negedge sys_clk);
    chk(routeUp, 32'h0);
    chk(zoneBlocked, 32'h0);
    rampKind = 3'h0;
    targetPosition = 32'h0;
    stp(103, 1'b1, 1'b0);
    @(negedge sys_clk);
    chk(stopRampStart, 32'h1);
    @(negedge sys_clk);
    chk(stopRampStart, 32'h0);
    chk(zoneBlocked, 32'h1);
    rampKind = 3'h4;
    rchk(7'h0E, 32'h2);
    rchk(7'h0E, 32'h0);
    targetPosition = 32'hFA;
    repeat (2) @(negedge sys_clk);
    chk(zoneBlocked, 32'h0);
    chk(routeUp, 32'h1);
  endtask : t_zone
  // Zone with the low limit below the high one, gated by the range
  task t_span;
    wr(7'h01, 32'h1);
    wr(7'h33, 32'hFFFF_FF9C);
    wr(7'h34, 32'h64);
    halfRange = 32'h0;
    wr(7'h01, 32'h7);
    @(negedge sys_clk);
    chk(stopRampStart, 32'h0);
    halfRange = 32'h12C;
    @(negedge sys_clk);
    chk(stopRampStart, 32'h1);
    chk(zoneBlocked, 32'h1);
    rchk(7'h0E, 32'h2);
  endtask : t_span

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // The full sequence needs under 250 cycles; twenty thousand means a hang
  initial begin
    #2000000;
    errorCnt++;
    give_verdict();
  end
  initial begin
    errorCnt = 0;
    checkCount = 0;
    rst_n = 1'b0;
    stepReq = 1'b0;
    stepUp = 1'b0;
    encStepReq = 1'b0;
    encStepUp = 1'b0;
    halfRange = 32'h0;
    targetPosition = 32'h0;
    rampKind = 3'h0;
    latchedPosition = 32'h1234_5678;
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    t_regs();
    t_turn();
    t_route();
    t_zone();
    t_span();
    give_verdict();
  end
endmodule : wrap_turn_counter_blocking_zone_test
